/* verilog/sesr_pkg.sv */
package sesr_pkg;

    // ==========================================================
    // standard event bit positions
    localparam int SESR_OPC_BIT   = 0;
    localparam int SESR_QRY_BIT   = 2;
    localparam int SESR_DEV_BIT   = 3;
    localparam int SESR_EXE_BIT   = 4;
    localparam int SESR_CMD_BIT   = 5;
    localparam int SESR_PWR_BIT   = 7;
    localparam logic [7:0] SESR_EVENT_USED = 8'hbd;
    localparam logic [7:0] SESR_FAULT_BITS = 8'h3c;

    // ==========================================================
    // status byte bit positions
    localparam int SESR_QUESTIONABLE_SUMMARY_BIT_BIT  = 3;
    localparam int SESR_MAV_BIT   = 4;
    localparam int SESR_ESB_BIT   = 5;
    localparam int SESR_RQS_BIT   = 6;
    localparam logic [7:0] SESR_STB_USED  = 8'h78;
    localparam logic [7:0] SESR_SRE_USED  = 8'hb8;

    // ==========================================================
    // reset values
    localparam logic [7:0]  SESR_EVENT_RESET = 8'h80;
    localparam logic [7:0]  SESR_MASK_RESET  = 8'h00;
    localparam logic [15:0] SESR_QMASK_RESET = 16'h0000;
    localparam int          SESR_QUESTIONABLE_SUMMARY_BIT_WIDTH  = 16;

    // ==========================================================
    // power-up mask handling states
    typedef enum logic [1:0] {
        SESR_PU_WAIT = 2'b00,
        SESR_PU_DONE = 2'b01
    } sesr_pu_t;

endpackage

/* verilog/sesr_event_bit.sv */
`timescale 1ns/1ps
module sesr_event_bit
    import sesr_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clock_in,
    input  wire logic rst_in,
    input  wire logic set_in,
    input  wire logic clear_in,
    output logic      flag_out
);

    // ==========================================================
    // sticky flag, set wins over clear
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            flag_out <= RESET_VAL;
        end else if (set_in) begin
            flag_out <= 1'b1;
        end else if (clear_in) begin
            flag_out <= 1'b0;
        end
    end

endmodule

/* verilog/sesr_status_event_summary_srq.sv */
`timescale 1ns/1ps
// Summary of operation
// - set op complete after operation complete
// - set query fault on buffer conditions
// - set selftest or calibration fault flag
// - set execution fault on failed command
// - set command fault on syntax error
// - power cycle flag held until read or clear-status
// - push error queue entry on bits 2-5
// - clear events on clear-status or read
// - event summary is masked OR
// - masks cleared by zero or power-on
// - output pending while output data waits
// - status byte bits 3-5 computed without latching
// - questionable summary from masked questionable bits
// - event summary bit; unused bits zero
// - service request from enabled summary bits
// - request cleared by poll or source read
// - serial poll clears only bit 6
// - status query returns byte, clears nothing
// - clear-status clears bits 5 and 6; read clears bit5
// - queries return binary weighted value
// - event bits latch; reset loads 8'h80
module sesr_status_event_summary_srq
    import sesr_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        op_complete_in,
    input  wire logic        query_fault_in,
    input  wire logic        selftest_cal_fault_in,
    input  wire logic        exec_fault_in,
    input  wire logic        command_fault_in,
    input  wire logic        clear_status_in,
    input  wire logic        event_read_in,
    input  wire logic        questionable_summary_bit_read_in,
    input  wire logic        serial_poll_in,
    input  wire logic        status_query_in,
    input  wire logic        event_mask_wr_in,
    input  wire logic [7:0]  event_mask_in,
    input  wire logic        srq_mask_wr_in,
    input  wire logic [7:0]  srq_mask_in,
    input  wire logic        questionable_summary_bit_mask_wr_in,
    input  wire logic [15:0] questionable_summary_bit_mask_in,
    input  wire logic        power_clear_wr_in,
    input  wire logic        power_clear_in,
    input  wire logic [15:0] questionable_summary_bit_event_in,
    input  wire logic        output_pending_in,
    output logic [7:0]       standard_event_latch_out,
    output logic [7:0]       status_summary_byte_out,
    output logic [7:0]       event_mask_out,
    output logic [7:0]       srq_mask_out,
    output logic [15:0]      questionable_summary_bit_mask_out,
    output logic             power_clear_out,
    output logic             error_push_out,
    output logic             service_request_out,
    output logic [7:0]       poll_byte_out,
    output logic             poll_valid_out,
    output logic [7:0]       query_byte_out,
    output logic             query_valid_out
);

    // ==========================================================
    // helpers
    function automatic logic any_masked(input logic [15:0] bits,
                                        input logic [15:0] mask);
        any_masked = |(bits & mask);
    endfunction

    // ==========================================================
    // event latch
    logic [7:0] next_set;
    logic [7:0] event_latch;
    logic       event_clear;

    always_comb begin
        next_set = 8'h00;
        next_set[SESR_OPC_BIT] = op_complete_in;
        next_set[SESR_QRY_BIT] = query_fault_in;
        next_set[SESR_DEV_BIT] = selftest_cal_fault_in;
        next_set[SESR_EXE_BIT] = exec_fault_in;
        next_set[SESR_CMD_BIT] = command_fault_in;
    end

    assign event_clear = clear_status_in | event_read_in;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_evt
            if (SESR_EVENT_USED[gi]) begin : g_used
                sesr_event_bit #(
                    .RESET_VAL (SESR_EVENT_RESET[gi])
                ) u_bit (
                    .clock_in (clock_in),
                    .rst_in   (rst_in),
                    .set_in   (next_set[gi]),
                    .clear_in (event_clear),
                    .flag_out (event_latch[gi])
                );
            end else begin : g_zero
                assign event_latch[gi] = 1'b0;
            end
        end
    endgenerate

    assign standard_event_latch_out = event_latch;

    // ==========================================================
    // error queue push on any fault bit set input, latched or not
    logic [7:0] fault_sel;
    assign fault_sel = SESR_FAULT_BITS;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            error_push_out <= 1'b0;
        end else begin
            error_push_out <= any_masked({8'h00, next_set}, {8'h00, fault_sel});
        end
    end

    // ==========================================================
    // power-on clear setting and masks
    sesr_pu_t pu_state;

    // setting survives power cycles, like the masks
    always_ff @(posedge clock_in) begin
        if (power_clear_wr_in) begin
            power_clear_out <= power_clear_in;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pu_state <= SESR_PU_WAIT;
        end else begin
            case (pu_state)
                SESR_PU_WAIT: pu_state <= SESR_PU_DONE;
                SESR_PU_DONE: pu_state <= SESR_PU_DONE;
                default:      pu_state <= SESR_PU_DONE;
            endcase
        end
    end

    // masks survive reset; cleared at power-up when setting is 1
    logic pu_clear;
    assign pu_clear = (pu_state == SESR_PU_WAIT) && power_clear_out;

    always_ff @(posedge clock_in) begin
        if (pu_clear) begin
            event_mask_out <= SESR_MASK_RESET;
        end else if (event_mask_wr_in) begin
            event_mask_out <= event_mask_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (pu_clear) begin
            srq_mask_out <= SESR_MASK_RESET;
        end else if (srq_mask_wr_in) begin
            srq_mask_out <= srq_mask_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (pu_clear) begin
            questionable_summary_bit_mask_out <= SESR_QMASK_RESET;
        end else if (questionable_summary_bit_mask_wr_in) begin
            questionable_summary_bit_mask_out <= questionable_summary_bit_mask_in;
        end
    end

    // ==========================================================
    // status byte summary, not latched
    logic questionable_summary_bit_sum;
    logic esb_sum;
    logic [7:0] summary;

    assign questionable_summary_bit_sum = any_masked(questionable_summary_bit_event_in, questionable_summary_bit_mask_out);
    assign esb_sum  = any_masked({8'h00, event_latch}, {8'h00, event_mask_out});

    always_comb begin
        summary = 8'h00;
        summary[SESR_QUESTIONABLE_SUMMARY_BIT_BIT] = questionable_summary_bit_sum;
        summary[SESR_MAV_BIT]  = output_pending_in;
        summary[SESR_ESB_BIT]  = esb_sum;
    end

    // ==========================================================
    // service request bit
    logic cause;
    logic service_request_bit;
    logic cause_q;

    assign cause = any_masked({8'h00, summary}, {8'h00, srq_mask_out & SESR_STB_USED});

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cause_q <= 1'b0;
        end else begin
            cause_q <= cause;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            service_request_bit <= 1'b0;
        end else if (cause && !cause_q) begin
            service_request_bit <= 1'b1;
        end else if (serial_poll_in || clear_status_in) begin
            service_request_bit <= 1'b0;
        end else if ((event_read_in || questionable_summary_bit_read_in) && service_request_bit) begin
            service_request_bit <= 1'b0;
        end
    end

    assign service_request_out = service_request_bit;

    always_comb begin
        status_summary_byte_out = summary;
        status_summary_byte_out[SESR_RQS_BIT] = service_request_bit;
    end

    // ==========================================================
    // poll and query answers
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            poll_valid_out <= 1'b0;
        end else begin
            poll_valid_out <= serial_poll_in;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            poll_byte_out <= 8'h00;
        end else if (serial_poll_in) begin
            poll_byte_out <= status_summary_byte_out;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            query_valid_out <= 1'b0;
        end else begin
            query_valid_out <= status_query_in;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            query_byte_out <= 8'h00;
        end else if (status_query_in) begin
            query_byte_out <= status_summary_byte_out;
        end
    end

endmodule

/* tb/sesr_monitor.sv */
`timescale 1ns/1ps
// ==========================================================
// status block checker
module sesr_monitor (
    input wire logic        clock_in, rst_in, op_complete_in, query_fault_in,
    input wire logic        selftest_cal_fault_in, exec_fault_in, command_fault_in,
    input wire logic        clear_status_in, event_read_in, questionable_summary_bit_read_in, serial_poll_in,
    input wire logic        status_query_in, output_pending_in,
    input wire logic [15:0] questionable_summary_bit_event_in, questionable_summary_bit_mask_out,
    input wire logic [7:0]  standard_event_latch_out, status_summary_byte_out,
    input wire logic [7:0]  event_mask_out, srq_mask_out, poll_byte_out, query_byte_out,
    input wire logic        error_push_out, service_request_out, poll_valid_out,
    input wire logic        query_valid_out
);
    wire logic       cause = |(status_summary_byte_out[5:3] & srq_mask_out[5:3]);
    wire logic       clr   = event_read_in | clear_status_in;
    wire logic [3:0] sets  = {command_fault_in, exec_fault_in, selftest_cal_fault_in,
                              query_fault_in};
    wire logic [7:0] lat   = standard_event_latch_out;
    wire logic [7:0] stb   = status_summary_byte_out;

    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // ==========================================================
    // assertions
    a_opc_sets: assert property (op_complete_in |=> lat[0])
        else $error("op complete bit not set");
    a_err_push: assert property (|(sets & ~lat[5:2]) |=> error_push_out)
        else $error("no error push");
    a_events_clear: assert property (clr && !(|sets) && !op_complete_in |=> lat == 8'h00)
        else $error("event latch not cleared");
    a_latch_holds: assert property (!clr |=> (lat & $past(lat)) == $past(lat))
        else $error("event bit lost");
    a_stb_form: assert property (!$past(rst_in) |-> stb == {1'b0, service_request_out,
        |(lat & event_mask_out), output_pending_in, |(questionable_summary_bit_event_in & questionable_summary_bit_mask_out), 3'b000})
        else $error("status byte wrong");
    a_rqs_rise: assert property (!$past(rst_in) && $rose(cause) |=> service_request_out)
        else $error("service request missing");
    a_rqs_clear: assert property ((serial_poll_in || questionable_summary_bit_read_in || clr) && !$rose(cause)
        |=> !service_request_out) else $error("service request kept");
    a_poll_byte: assert property (serial_poll_in |=> poll_valid_out && poll_byte_out == $past(stb))
        else $error("poll byte wrong");
    a_query_byte: assert property (status_query_in |=> query_valid_out
        && query_byte_out == $past(stb)) else $error("query byte wrong");

    c_request: cover property ($rose(service_request_out));
    c_poll: cover property (serial_poll_in && service_request_out);
    c_push: cover property (error_push_out);
endmodule

bind sesr_status_event_summary_srq sesr_monitor u_monitor (.*);

/* tb/sesr_ctrl_model.sv */
`timescale 1ns/1ps
// ==========================================================
// bus controller: polls once service is requested
module sesr_ctrl_model (
    input  wire logic       clock_in,
    input  wire logic       enable_in,
    input  wire logic       srq_in,
    input  wire logic       poll_valid_in,
    input  wire logic [7:0] poll_byte_in,
    output logic            poll_out = 1'b0,
    output logic [7:0]      seen_out = 8'h00,
    output int              polls_out = 0
);
    always @(negedge clock_in) begin
        poll_out <= enable_in && srq_in && !poll_out;
    end
    always @(posedge clock_in) begin
        if (poll_valid_in) begin
            seen_out  <= poll_byte_in;
            polls_out <= polls_out + 1;
        end
    end
endmodule

/* tb/sesr_status_event_summary_srq_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// status block testbench
module sesr_status_event_summary_srq_tb;
    logic        clock_in, rst_in, mask_wr, pend, ctl_en, poll, push, service_request_bit, pvalid, qvalid, pclr;
    logic [8:0]  pl;
    logic        pcw, pcv;
    logic [7:0]  emask, smask, latch, stb, emask_q, smask_q, pbyte, qbyte, seen;
    logic [15:0] qmask, questionable_summary_bit_ev, qmask_q;
    int          polls, error_cnt, n_tests;

    sesr_status_event_summary_srq uut (
        .clock_in(clock_in), .rst_in(rst_in), .op_complete_in(pl[0]),
        .query_fault_in(pl[1]), .selftest_cal_fault_in(pl[2]), .exec_fault_in(pl[3]),
        .command_fault_in(pl[4]), .clear_status_in(pl[5]), .event_read_in(pl[6]),
        .questionable_summary_bit_read_in(pl[7]), .serial_poll_in(poll), .status_query_in(pl[8]),
        .event_mask_wr_in(mask_wr), .event_mask_in(emask), .srq_mask_wr_in(mask_wr),
        .srq_mask_in(smask), .questionable_summary_bit_mask_wr_in(mask_wr), .questionable_summary_bit_mask_in(qmask),
        .power_clear_wr_in(pcw), .power_clear_in(pcv), .questionable_summary_bit_event_in(questionable_summary_bit_ev),
        .output_pending_in(pend), .standard_event_latch_out(latch),
        .status_summary_byte_out(stb), .event_mask_out(emask_q), .srq_mask_out(smask_q),
        .questionable_summary_bit_mask_out(qmask_q), .power_clear_out(pclr), .error_push_out(push),
        .service_request_out(service_request_bit), .poll_byte_out(pbyte), .poll_valid_out(pvalid),
        .query_byte_out(qbyte), .query_valid_out(qvalid));
    sesr_ctrl_model ctl (.clock_in(clock_in), .enable_in(ctl_en), .srq_in(service_request_bit),
        .poll_valid_in(pvalid), .poll_byte_in(pbyte), .poll_out(poll), .seen_out(seen),
        .polls_out(polls));

    // ==========================================================
    // helpers
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic pulse(input int k);
        pl[k] = 1'b1;
        @(negedge clock_in);
        pl[k] = 1'b0;
    endtask
    task automatic wr_masks(input logic [7:0] e, s, input logic [15:0] q);
        {emask, smask, qmask, mask_wr} = {e, s, q, 1'b1};
        @(negedge clock_in);
        mask_wr = 1'b0;
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_events();
        logic [7:0] exp;
        exp = 8'h80;
        chk("latch", exp, latch);
        chk("masks", 8'h00, emask_q | smask_q);
        chk("pclr", 1'b1, pclr);
        for (int k = 0; k < 5; k++) begin
            pulse(k);
            exp[k == 0 ? 0 : k + 1] = 1'b1;
            chk("latch", exp, latch);
            chk("push", k > 0, push);
        end
        @(negedge clock_in);
        chk("latch", 8'hbd, latch);
        pulse(6);
        chk("latch", 8'h00, latch);
    endtask
    task automatic t_summary();
        wr_masks(8'h10, 8'h20, 16'h2000);
        pulse(3);
        @(negedge clock_in);
        chk("stb", 8'h60, stb);
        pulse(8);
        chk("query", 9'h160, {qvalid, qbyte});
        chk("rqs", 1'b1, service_request_bit);
        ctl_en = 1'b1;
        for (int i = 0; i < 10 && polls == 0; i++) @(negedge clock_in);
        ctl_en = 1'b0;
        chk("poll", 8'h60, seen);
        chk("stb", 8'h20, stb);
        {questionable_summary_bit_ev, pend} = {16'h2000, 1'b1};
        #1;
        chk("stb", 8'h38, stb);
        pend = 1'b0;
        #1;
        chk("stb", 8'h28, stb);
        pulse(6);
        chk("stb", 8'h08, stb);
        wr_masks(8'h10, 8'h08, 16'h2000);
        @(negedge clock_in);
        chk("stb", 8'h48, stb);
        pulse(7);
        chk("stb", 8'h08, stb);
        pulse(3);
        pulse(5);
        chk("latch", 8'h00, latch);
        chk("stb", 8'h08, stb);
        wr_masks(8'h00, 8'h00, 16'h0000);
        chk("masks", 8'h00, emask_q | smask_q | qmask_q);
        chk("stb", 8'h00, stb);
    endtask
    task automatic t_power();
        {pcv, pcw} = 2'b01;
        @(negedge clock_in);
        pcw = 1'b0;
        chk("pclr", 1'b0, pclr);
        wr_masks(8'h10, 8'h20, 16'h2000);
        rst_in = 1'b1;
        repeat (2) @(negedge clock_in);
        rst_in = 1'b0;
        repeat (2) @(negedge clock_in);
        chk("latch", 8'h80, latch);
        chk("emask", 8'h10, emask_q);
        chk("smask", 8'h20, smask_q);
        chk("qmask", 16'h2000, qmask_q);
        chk("pclr", 1'b0, pclr);
        chk("stb", 8'h08, stb);
    endtask

    // ==========================================================
    // clock, sequence, watchdog
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    initial begin
        {rst_in, pl, mask_wr, pend, ctl_en} = {1'b1, 9'h000, 3'b000};
        {emask, smask, qmask, questionable_summary_bit_ev} = '0;
        {pcw, pcv} = 2'b11;
        error_cnt = 0;
        n_tests = 0;
        repeat (8) @(negedge clock_in);
        rst_in = 1'b0;
        pcw = 1'b0;
        repeat (2) @(negedge clock_in);
        t_events();
        t_summary();
        t_power();
        wrap_up();
    end
    initial begin
        #20000;
        error_cnt++;
        wrap_up();
    end
endmodule
